// File: sws_pkg.sv
// shared constants and types for the supply and wake status block
// What this block does
// [RQ1] Power-on, brown-out, reset-pin or watchdog reset sets the first-level reset flag.
// [RQ2] A reset event of any other level clears the first-level reset flag.
// [RQ3] Wake from Sleep or Deep Sleep by an IO event reads as IO wake flag 1.
// [RQ4] Timer wake reads timer-or-pulse flag 1 with pulse qualifier 0.
// [RQ5] Metering pulse wake reads timer-or-pulse flag 1 and pulse qualifier 1.
// [RQ6] Mains sense below 1.0 V sets the supply-loss flag, a power-down event.
// [RQ7] With power-down interrupt enabled, supply-loss flag rising raises the interrupt.
// [RQ8] Mains sense above 1.1 V keeps the supply-loss flag at 0.
// [RQ9] Mains sense above 1.1 V reads the line-supply flag as 1.
// [RQ10] Mains sense below 1.0 V keeps the line-supply flag at 0.
// [RQ11] Power detector is on after reset; writing detector-disable 1 turns it off.
// [RQ12] IO regulator level comes from regulator control bits 5 down to 3.
// [RQ13] Core supply level comes from regulator control bits 2 down to 0.
// [RQ14] Between 1.0 V and 1.1 V both supply flags keep their previous values.
package sws_pkg;
    // bus geometry: registers sit at word index, byte address is four times it
    localparam int unsigned WB_DW     = 32;
    localparam int unsigned WB_SW     = 4;
    localparam int unsigned IDX_W     = 16;
    localparam int unsigned ADR_W_MIN = 18;
    localparam int unsigned REG_W     = 8;

    // register indices
    localparam logic [15:0] IDX_SYSTEM_STATE = 16'h00A1;
    localparam logic [15:0] IDX_WAKE_DETECT  = 16'h00AF;
    localparam logic [15:0] IDX_REG_CTRL     = 16'h2866;
    localparam logic [15:0] IDX_IRQ_STATUS   = 16'h2870;
    localparam logic [15:0] IDX_IRQ_CLEAR    = 16'h2871;
    localparam logic [15:0] IDX_IRQ_ENABLE   = 16'h2872;

    // system_state fields
    localparam int unsigned SS_RESET_L1_BIT    = 5;
    localparam int unsigned SS_IO_WAKE_BIT     = 3;
    localparam int unsigned SS_TIMER_PULSE_BIT = 2;
    localparam int unsigned SS_SUPPLY_LOSS_BIT = 1;
    localparam int unsigned SS_LINE_BIT        = 0;

    // wake_detect_register field
    localparam int unsigned WD_PULSE_QUAL_BIT = 3;

    // regulator_control fields and reset value
    localparam int unsigned RC_DET_DIS_BIT  = 7;
    localparam int unsigned RC_IO_SEL_LSB   = 3;
    localparam int unsigned RC_CORE_SEL_LSB = 0;
    localparam int unsigned SEL_W           = 3;
    localparam logic [7:0]  REG_CTRL_RST    = 8'h00;
    localparam logic [7:0]  REG_CTRL_MASK   = 8'hBF;

    // interrupt bits, same layout in status, clear and enable
    localparam int unsigned IRQ_W           = 4;
    localparam int unsigned IRQ_SUPPLY_LOSS = 0;
    localparam int unsigned IRQ_LINE_UP     = 1;
    localparam int unsigned IRQ_RESET_L1    = 2;
    localparam int unsigned IRQ_WAKE        = 3;
    localparam logic [3:0]  IRQ_ENABLE_RST  = 4'h0;

    typedef enum logic [1:0] {
        SWS_SUP_NONE,
        SWS_SUP_LINE,
        SWS_SUP_LOST
    } sws_supply_e;

    typedef enum logic [1:0] {
        SWS_WAKE_NONE,
        SWS_WAKE_IO,
        SWS_WAKE_TIMER,
        SWS_WAKE_PULSE
    } sws_wake_e;
endpackage

// File: sws_sense.sv
`timescale 1ns/1ps
// mains sense synchroniser and hysteresis tracker
module sws_sense (
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // comparator outputs of the divided mains sense, asynchronous
    input  wire logic  above_hi_i,
    input  wire logic  below_lo_i,
    // status towards the register block
    sws_sense_if.sense sense
);
    import sws_pkg::*;

    wire  [1:0]  raw;
    wire  [1:0]  sync;
    sws_supply_e state;
    sws_supply_e next_state;
    logic        loss_evt;
    logic        line_evt;

    assign raw = {below_lo_i, above_hi_i};

    for (genvar i = 0; i < 2; i++) begin : g_sync
        logic meta_q;
        logic sync_q;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
            end else begin
                meta_q <= raw[i];
                sync_q <= meta_q;
            end
        end
        assign sync[i] = sync_q;
    end

    // low wins over high so a glitching divider never reports line power
    always_comb begin
        next_state = state;
        if (sense.enable) begin
            if (sync[1]) begin
                next_state = SWS_SUP_LOST; // [RQ6] [RQ10]
            end else if (sync[0]) begin
                next_state = SWS_SUP_LINE; // [RQ9] [RQ8]
            end
        end
    end

    // inside the band neither comparator fires, so the state holds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SWS_SUP_NONE;
        end else begin
            state <= next_state; // [RQ14]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loss_evt <= 1'b0;
            line_evt <= 1'b0;
        end else begin
            loss_evt <= (next_state == SWS_SUP_LOST) && (state != SWS_SUP_LOST);
            line_evt <= (next_state == SWS_SUP_LINE) && (state != SWS_SUP_LINE);
        end
    end

    assign sense.state    = state;
    assign sense.loss_evt = loss_evt;
    assign sense.line_evt = line_evt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_loss_on_low: assert property ( // [RQ6]
        sense.enable && sync[1] |=> state == SWS_SUP_LOST
    ) else $error("supply loss not flagged below low threshold");

    a_line_on_high: assert property ( // [RQ9]
        sense.enable && sync[0] && !sync[1] |=> state == SWS_SUP_LINE
    ) else $error("line supply not flagged above high threshold");

    a_band_hold: assert property ( // [RQ14]
        !sync[0] && !sync[1] |=> state == $past(state)
    ) else $error("supply state moved inside hysteresis band");

    a_loss_pulse: assert property ( // [RQ6]
        loss_evt |-> state == SWS_SUP_LOST && $past(state) != SWS_SUP_LOST
    ) else $error("loss event without entry into loss state");
endmodule

// File: sws_sense_if.sv
`timescale 1ns/1ps
// supply tracker status carried between the sense tracker and the register block
interface sws_sense_if;
    import sws_pkg::*;
    logic        enable;
    sws_supply_e state;
    logic        loss_evt;
    logic        line_evt;

    modport sense (
        input  enable,
        output state,
        output loss_evt,
        output line_evt
    );
    modport ctrl (
        output enable,
        input  state,
        input  loss_evt,
        input  line_evt
    );
endinterface

// File: sws_top.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
// supply and wake status block: wishbone registers, cause flags and interrupt
module sws_top #(
    parameter int unsigned ADR_W = 18
) (
    // clock and reset
    input  wire  logic                       clk_i,
    input  wire  logic                       rst_i,
    // wishbone classic slave
    input  wire  logic                       wb_cyc_i,
    input  wire  logic                       wb_stb_i,
    input  wire  logic                       wb_we_i,
    input  wire  logic [ADR_W-1:0]           wb_adr_i,
    input  wire  logic [sws_pkg::WB_SW-1:0]  wb_sel_i,
    input  wire  logic [sws_pkg::WB_DW-1:0]  wb_dat_i,
    output logic       [sws_pkg::WB_DW-1:0]  wb_dat_o,
    output logic                             wb_ack_o,
    // divided mains sense comparators, asynchronous
    input  wire  logic                       sense_above_hi_i,
    input  wire  logic                       sense_below_lo_i,
    // reset and wake events, one-cycle pulses on clk_i
    input  wire  logic                       por_bor_evt_i,
    input  wire  logic                       ext_reset_pin_evt_i,
    input  wire  logic                       wdt_overflow_evt_i,
    input  wire  logic                       other_level_reset_evt_i,
    input  wire  logic                       io_wake_evt_i,
    input  wire  logic                       timer_wake_evt_i,
    input  wire  logic                       pulse_wake_evt_i,
    // regulator and detector controls
    output logic                             detector_disable_o,
    output logic       [sws_pkg::SEL_W-1:0]  io_regulator_level_sel_o,
    output logic       [sws_pkg::SEL_W-1:0]  core_regulator_level_sel_o,
    // supply status and interrupt
    output logic                             line_supply_flag_o,
    output logic                             supply_loss_flag_o,
    output logic                             irq_o
);
    import sws_pkg::*;

    if (ADR_W < ADR_W_MIN) begin : g_bad_adr_w
        $error("ADR_W too small to reach the register indices");
    end

    sws_sense_if sense_if ();

    logic             bus_req;
    logic             wr_stb;
    logic             wr_ctrl;
    logic             wr_clear;
    logic             wr_enable;
    logic             l1_evt;
    logic             wake_evt;
    logic             reset_l1;
    sws_wake_e        wake;
    logic [REG_W-1:0] reg_ctrl;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] irq_evt;
    wire  [IRQ_W-1:0] next_irq_status;
    logic [REG_W-1:0] ss_val;
    logic [REG_W-1:0] wd_val;
    logic [WB_DW-1:0] next_dat;

    // true when the word address selects the given register index
    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
        hit = adr[ADR_W-1:2] == (ADR_W-2)'(idx);
    endfunction

    sws_sense u_sense (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .above_hi_i (sense_above_hi_i),
        .below_lo_i (sense_below_lo_i),
        .sense      (sense_if.sense)
    );

    // the comparators only run while the detector is powered
    assign sense_if.enable = ~reg_ctrl[RC_DET_DIS_BIT]; // [RQ11]

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------

    // a new request is seen only while ack is low, so each cycle acks once
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // writes land on the edge at which the master samples ack
    assign wr_stb    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign wr_ctrl   = wr_stb && hit(wb_adr_i, IDX_REG_CTRL);
    assign wr_clear  = wr_stb && hit(wb_adr_i, IDX_IRQ_CLEAR);
    assign wr_enable = wr_stb && hit(wb_adr_i, IDX_IRQ_ENABLE);

    // ------------------------------------------------------------------
    // reset and wake cause flags
    // ------------------------------------------------------------------

    assign l1_evt   = por_bor_evt_i || ext_reset_pin_evt_i || wdt_overflow_evt_i;
    assign wake_evt = io_wake_evt_i || timer_wake_evt_i || pulse_wake_evt_i;

    // a first-level event beats another level arriving in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_l1 <= 1'b0;
        end else if (l1_evt) begin
            reset_l1 <= 1'b1; // [RQ1]
        end else if (other_level_reset_evt_i) begin
            reset_l1 <= 1'b0; // [RQ2]
        end
    end

    // only the latest wake cause is kept; any reset event forgets it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake <= SWS_WAKE_NONE;
        end else if (pulse_wake_evt_i) begin
            wake <= SWS_WAKE_PULSE; // [RQ5]
        end else if (timer_wake_evt_i) begin
            wake <= SWS_WAKE_TIMER; // [RQ4]
        end else if (io_wake_evt_i) begin
            wake <= SWS_WAKE_IO; // [RQ3]
        end else if (l1_evt || other_level_reset_evt_i) begin
            wake <= SWS_WAKE_NONE;
        end
    end

    // ------------------------------------------------------------------
    // regulator control
    // ------------------------------------------------------------------

    // bit 6 has no function and is never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_ctrl <= REG_CTRL_RST; // [RQ11]
        end else if (wr_ctrl) begin
            reg_ctrl <= wb_dat_i[REG_W-1:0] & REG_CTRL_MASK; // [RQ11] [RQ12] [RQ13]
        end
    end

    assign detector_disable_o         = reg_ctrl[RC_DET_DIS_BIT]; // [RQ11]
    assign io_regulator_level_sel_o   = reg_ctrl[RC_IO_SEL_LSB +: SEL_W]; // [RQ12]
    assign core_regulator_level_sel_o = reg_ctrl[RC_CORE_SEL_LSB +: SEL_W]; // [RQ13]

    // pin copies of the supply flags, one cycle behind the tracker
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_supply_flag_o <= 1'b0;
            supply_loss_flag_o <= 1'b0;
        end else begin
            line_supply_flag_o <= sense_if.state == SWS_SUP_LINE; // [RQ9] [RQ10]
            supply_loss_flag_o <= sense_if.state == SWS_SUP_LOST; // [RQ6] [RQ8]
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------

    always_comb begin
        irq_evt                  = '0;
        irq_evt[IRQ_SUPPLY_LOSS] = sense_if.loss_evt; // [RQ7]
        irq_evt[IRQ_LINE_UP]     = sense_if.line_evt;
        irq_evt[IRQ_RESET_L1]    = l1_evt;
        irq_evt[IRQ_WAKE]        = wake_evt;
    end

    // an event in the same cycle as its clear keeps the bit set
    for (genvar b = 0; b < IRQ_W; b++) begin : g_irq
        assign next_irq_status[b] = irq_evt[b] ||
                                    (irq_status[b] && !(wr_clear && wb_dat_i[b]));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_enable <= IRQ_ENABLE_RST;
        end else if (wr_enable) begin
            irq_enable <= wb_dat_i[IRQ_W-1:0];
        end
    end

    // registered so the pin is glitch free; costs one cycle of latency
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_enable); // [RQ7]
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------

    always_comb begin
        ss_val                     = '0;
        ss_val[SS_RESET_L1_BIT]    = reset_l1; // [RQ1] [RQ2]
        ss_val[SS_IO_WAKE_BIT]     = wake == SWS_WAKE_IO; // [RQ3]
        ss_val[SS_TIMER_PULSE_BIT] = (wake == SWS_WAKE_TIMER) ||
                                     (wake == SWS_WAKE_PULSE); // [RQ4] [RQ5]
        ss_val[SS_SUPPLY_LOSS_BIT] = sense_if.state == SWS_SUP_LOST; // [RQ6] [RQ8]
        ss_val[SS_LINE_BIT]        = sense_if.state == SWS_SUP_LINE; // [RQ9] [RQ10]
    end

    always_comb begin
        wd_val                    = '0;
        wd_val[WD_PULSE_QUAL_BIT] = wake == SWS_WAKE_PULSE; // [RQ4] [RQ5]
    end

    // unmapped and write-only indices read as zero
    always_comb begin
        next_dat = '0;
        if (hit(wb_adr_i, IDX_SYSTEM_STATE)) begin
            next_dat[REG_W-1:0] = ss_val;
        end else if (hit(wb_adr_i, IDX_WAKE_DETECT)) begin
            next_dat[REG_W-1:0] = wd_val;
        end else if (hit(wb_adr_i, IDX_REG_CTRL)) begin
            next_dat[REG_W-1:0] = reg_ctrl;
        end else if (hit(wb_adr_i, IDX_IRQ_STATUS)) begin
            next_dat[IRQ_W-1:0] = irq_status;
        end else if (hit(wb_adr_i, IDX_IRQ_ENABLE)) begin
            next_dat[IRQ_W-1:0] = irq_enable;
        end
    end

    // data is captured with the request and held while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (bus_req) begin
            wb_dat_o <= next_dat;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_loss_seen;
        sense_if.loss_evt && irq_enable[IRQ_SUPPLY_LOSS] && !wr_enable;
    endsequence

    sequence s_irq_raised;
        irq_status[IRQ_SUPPLY_LOSS] ##1 irq_o;
    endsequence

    a_l1_flag_set: assert property ( // [RQ1]
        l1_evt |=> ss_val[SS_RESET_L1_BIT]
    ) else $error("first-level reset flag not set");

    a_l1_flag_clr: assert property ( // [RQ2]
        other_level_reset_evt_i && !l1_evt |=> !ss_val[SS_RESET_L1_BIT]
    ) else $error("first-level reset flag not cleared by other level");

    a_io_wake_read: assert property ( // [RQ3]
        io_wake_evt_i && !timer_wake_evt_i && !pulse_wake_evt_i
        |=> ss_val[SS_IO_WAKE_BIT] && !ss_val[SS_TIMER_PULSE_BIT]
    ) else $error("io wake not reported");

    a_timer_wake_read: assert property ( // [RQ4]
        timer_wake_evt_i && !pulse_wake_evt_i
        |=> ss_val[SS_TIMER_PULSE_BIT] && !wd_val[WD_PULSE_QUAL_BIT]
    ) else $error("timer wake not reported");

    a_pulse_wake_read: assert property ( // [RQ5]
        pulse_wake_evt_i
        |=> ss_val[SS_TIMER_PULSE_BIT] && wd_val[WD_PULSE_QUAL_BIT]
    ) else $error("pulse wake not reported");

    a_loss_irq_path: assert property ( // [RQ7]
        s_loss_seen |=> s_irq_raised
    ) else $error("power-down interrupt not raised");

    a_loss_flag_read: assert property ( // [RQ6]
        sense_if.loss_evt |-> ss_val[SS_SUPPLY_LOSS_BIT] && !ss_val[SS_LINE_BIT]
        ##1 supply_loss_flag_o && !line_supply_flag_o
    ) else $error("supply loss not visible");

    a_ctrl_write_take: assert property ( // [RQ12]
        wr_ctrl |=> io_regulator_level_sel_o == $past(wb_dat_i[5:3])
                 && core_regulator_level_sel_o == $past(wb_dat_i[2:0])
                 && detector_disable_o == $past(wb_dat_i[7])
    ) else $error("regulator control write not taken");

    a_det_gates_sense: assert property ( // [RQ11]
        detector_disable_o |=> sense_if.state == $past(sense_if.state)
    ) else $error("supply state moved with detector disabled");

    a_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o
    ) else $error("ack held longer than one cycle");

    a_clear_set_wins: assert property (
        wr_clear && wb_dat_i[IRQ_WAKE] && wake_evt |=> irq_status[IRQ_WAKE]
    ) else $error("event lost against simultaneous clear");
endmodule

// File: tb.sv
`timescale 1ns/1ps
// self-checking bench for the supply and wake status block, driven over wishbone
module tb;
    import sws_pkg::*;

    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [17:0] wb_adr_i = '0;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        above_hi = 1'b0;
    logic        below_lo = 1'b0;
    // por, pin, watchdog, other level, io, timer, pulse
    logic [6:0]  evt      = '0;
    logic        det_dis;
    logic [2:0]  io_sel;
    logic [2:0]  core_sel;
    logic        line_o;
    logic        loss_o;
    logic        irq_o;
    logic [31:0] rd;
    int          failures   = 0;
    int          num_checks = 0;

    always #5 clk_i = ~clk_i;

    sws_top #(.ADR_W(18)) sws_top_inst (
        .clk_i                      (clk_i),
        .rst_i                      (rst_i),
        .wb_cyc_i                   (wb_cyc_i),
        .wb_stb_i                   (wb_stb_i),
        .wb_we_i                    (wb_we_i),
        .wb_adr_i                   (wb_adr_i),
        .wb_sel_i                   (wb_sel_i),
        .wb_dat_i                   (wb_dat_i),
        .wb_dat_o                   (wb_dat_o),
        .wb_ack_o                   (wb_ack_o),
        .sense_above_hi_i           (above_hi),
        .sense_below_lo_i           (below_lo),
        .por_bor_evt_i              (evt[0]),
        .ext_reset_pin_evt_i        (evt[1]),
        .wdt_overflow_evt_i         (evt[2]),
        .other_level_reset_evt_i    (evt[3]),
        .io_wake_evt_i              (evt[4]),
        .timer_wake_evt_i           (evt[5]),
        .pulse_wake_evt_i           (evt[6]),
        .detector_disable_o         (det_dis),
        .io_regulator_level_sel_o   (io_sel),
        .core_regulator_level_sel_o (core_sel),
        .line_supply_flag_o         (line_o),
        .supply_loss_flag_o         (loss_o),
        .irq_o                      (irq_o)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; the ack is seen as the value before each edge
    task automatic wb_access(input logic we, input logic [15:0] idx, input logic [7:0] wd,
                             input logic [3:0] sel, output logic [31:0] rdat);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            $display("[ERR] %0t no bus answer", $time);
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        wb_access(1'b1, idx, wd, 4'hF, rd);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
        wb_access(1'b0, idx, 8'h00, 4'hF, rd);
        check(rd, {24'h000000, exp});
    endtask

    task automatic pulse(input int i);
        @(posedge clk_i);
        evt[i] <= 1'b1;
        @(posedge clk_i);
        evt[i] <= 1'b0;
    endtask

    // sync path, tracker, flag copy and irq need six edges at most
    task automatic sense(input logic hi, input logic lo);
        @(posedge clk_i);
        above_hi <= hi;
        below_lo <= lo;
        repeat (6) @(posedge clk_i);
    endtask

    initial begin
        repeat (3000) @(posedge clk_i);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(IDX_REG_CTRL, 8'h00);
        check({31'h0, det_dis}, 32'h0);
        rd_chk(IDX_SYSTEM_STATE, 8'h00);
        wr(IDX_REG_CTRL, 8'hFF);
        rd_chk(IDX_REG_CTRL, 8'hBF);
        check({25'h0, det_dis, io_sel, core_sel}, 32'h7F);
        wr(IDX_REG_CTRL, 8'h1A);
        rd_chk(IDX_REG_CTRL, 8'h1A);
        check({25'h0, det_dis, io_sel, core_sel}, 32'h1A);
        // lane 0 disabled: write acked but dropped
        wb_access(1'b1, IDX_REG_CTRL, 8'h00, 4'hE, rd);
        rd_chk(IDX_REG_CTRL, 8'h1A);
        wr(16'h0123, 8'h55);
        rd_chk(16'h0123, 8'h00);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            rd_chk(IDX_SYSTEM_STATE, 8'h20);
            pulse(3);
            rd_chk(IDX_SYSTEM_STATE, 8'h00);
        end
        pulse(4);
        rd_chk(IDX_SYSTEM_STATE, 8'h08);
        pulse(5);
        rd_chk(IDX_SYSTEM_STATE, 8'h04);
        rd_chk(IDX_WAKE_DETECT, 8'h00);
        pulse(6);
        rd_chk(IDX_SYSTEM_STATE, 8'h04);
        rd_chk(IDX_WAKE_DETECT, 8'h08);
        // reset and wake events must have left their sticky bits
        rd_chk(IDX_IRQ_STATUS, 8'h0C);
        wr(IDX_IRQ_CLEAR, 8'h0F);
        rd_chk(IDX_IRQ_STATUS, 8'h00);
        wr(IDX_IRQ_ENABLE, 8'h01);
        rd_chk(IDX_IRQ_ENABLE, 8'h01);
        sense(1'b1, 1'b0);
        rd_chk(IDX_SYSTEM_STATE, 8'h05);
        check({30'h0, line_o, loss_o}, 32'h2);
        check({31'h0, irq_o}, 32'h0);
        rd_chk(IDX_IRQ_STATUS, 8'h02);
        sense(1'b0, 1'b0);
        rd_chk(IDX_SYSTEM_STATE, 8'h05);
        // detector off: supply state must freeze
        wr(IDX_REG_CTRL, 8'h80);
        sense(1'b0, 1'b1);
        rd_chk(IDX_SYSTEM_STATE, 8'h05);
        wr(IDX_REG_CTRL, 8'h00);
        repeat (6) @(posedge clk_i);
        rd_chk(IDX_SYSTEM_STATE, 8'h06);
        check({30'h0, line_o, loss_o}, 32'h1);
        check({31'h0, irq_o}, 32'h1);
        rd_chk(IDX_IRQ_STATUS, 8'h03);
        sense(1'b0, 1'b0);
        rd_chk(IDX_SYSTEM_STATE, 8'h06);
        wr(IDX_IRQ_ENABLE, 8'h00);
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wr(IDX_IRQ_ENABLE, 8'h01);
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        wr(IDX_IRQ_CLEAR, 8'h01);
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd_chk(IDX_IRQ_STATUS, 8'h02);
        rd_chk(IDX_IRQ_CLEAR, 8'h00);
        wr(IDX_SYSTEM_STATE, 8'hFF);
        rd_chk(IDX_SYSTEM_STATE, 8'h06);
        // clear and io wake land on one edge: the event must win
        fork
            wr(IDX_IRQ_CLEAR, 8'h08);
            begin
                @(posedge clk_i);
                pulse(4);
            end
        join
        rd_chk(IDX_IRQ_STATUS, 8'h0A);
        rd_chk(IDX_SYSTEM_STATE, 8'h0A);
        sense(1'b1, 1'b0);
        rd_chk(IDX_SYSTEM_STATE, 8'h09);
        // both comparators high counts as below the low threshold
        sense(1'b1, 1'b1);
        rd_chk(IDX_SYSTEM_STATE, 8'h0A);
        check({31'h0, irq_o}, 32'h1);
        // mid-run reset with the divider parked inside the band
        sense(1'b0, 1'b0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(IDX_IRQ_ENABLE, 8'h00);
        rd_chk(IDX_IRQ_STATUS, 8'h00);
        rd_chk(IDX_SYSTEM_STATE, 8'h00);
        rd_chk(IDX_REG_CTRL, 8'h00);
        check({29'h0, line_o, loss_o, irq_o}, 32'h0);
        complete_run();
    end
endmodule
